// ### core/p9pf_port.sv
`timescale 1ns/100ps
`include "p9pf_consts.svh"
// Summary of operation
// - Read of output pin returns latch
// - Read of input pin returns live level
// - Input pin pull-up follows data bit
// - Pins 0-2 feed interrupts, pin 0 trigger
// - Expanded modes: pins 3,4 drive strobes
// - Single-chip, no dual-port: pins 3,4 general
// - Slave: pins 3,4 take select, enable inputs
// - Pin 5 address strobe or ready output
// - Pin 6 drives system clock when selected
// - Pin 7 wait or write-enable input
// - Reset sets direction by operating mode
// - Hardware standby: all pins float, no pull-ups
// - Software standby holds pins, strobes high
// - Direction bit one makes pin output
module p9pf_port (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Chip mode and standby
  input wire logic [1:0] mode_sel,
  input wire logic hw_standby,
  input wire logic sw_standby,
  // Bus controller and clock sources
  input wire logic rd_strobe_n,
  input wire logic wr_strobe_n,
  input wire logic address_strobe_n,
  input wire logic dp_ready_n,
  input wire logic sys_clk_level,
  // Port pins
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output logic [7:0] pin_pullup,
  // Signals taken from the pins
  output logic [2:0] irq_n,
  output logic adc_trigger_n,
  output logic bus_wait_n,
  output logic dp_select_n,
  output logic dp_output_en_n,
  output logic dp_write_en_n,
  // Control register view
  output logic dual_port_enable
);
  // ----------------------------------------
  // Decoding
  // ----------------------------------------
  function automatic logic addr_hit(input logic [31:0] a, input logic [15:0] idx);
    addr_hit = (a == {14'h0000, idx, 2'b00});
  endfunction : addr_hit

  function automatic logic is_expanded(input logic [1:0] md);
    is_expanded = (md == `P9PF_MODE_EXP1) || (md == `P9PF_MODE_EXP2);
  endfunction : is_expanded

  p9pf_pkg::p9pf_apb_state_t state_reg;
  p9pf_pkg::p9pf_byte_t port_direction_bits;
  p9pf_pkg::p9pf_byte_t port_data_latch;
  logic dp_enable_reg;
  logic init_done_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [7:0] pin_out_reg;
  logic [7:0] pin_oe_reg;
  logic [7:0] pin_pullup_reg;
  logic [2:0] irq_n_reg;
  logic adc_trigger_n_reg;
  logic bus_wait_n_reg;
  logic dp_select_n_reg;
  logic dp_output_en_n_reg;
  logic dp_write_en_n_reg;
  logic setup;
  logic wr_take;
  logic hit_ddr;
  logic hit_dr;
  logic hit_ctrl;
  logic mode_exp;
  logic slave;
  p9pf_pkg::p9pf_byte_t read_view;

  p9pf_mux_if mx ();

  assign setup = psel && !penable;
  assign wr_take = psel && penable && pready_reg && pwrite;
  assign hit_ddr = addr_hit(paddr, `P9PF_DDR_IDX);
  assign hit_dr = addr_hit(paddr, `P9PF_DR_IDX);
  assign hit_ctrl = addr_hit(paddr, `P9PF_CTRL_IDX);
  assign mode_exp = is_expanded(mode_sel);
  assign slave = !mode_exp && dp_enable_reg;
  // Outputs read the latch, inputs bypass it
  assign read_view = (port_direction_bits & port_data_latch) |
                     (~port_direction_bits & pin_in);

  // ----------------------------------------
  // APB slave: one wait-free access phase
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= p9pf_pkg::P9PF_IDLE;
    end else begin
      case (state_reg)
        p9pf_pkg::P9PF_IDLE: begin
          if (setup) begin
            state_reg <= p9pf_pkg::P9PF_ACCESS;
          end
        end
        p9pf_pkg::P9PF_ACCESS: begin
          state_reg <= p9pf_pkg::P9PF_IDLE;
        end
        default: begin
          state_reg <= p9pf_pkg::P9PF_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= setup;
      pslverr_reg <= setup && !(hit_ddr || hit_dr || hit_ctrl);
      if (setup && !pwrite) begin
        // Direction register is write-only and reads as zero
        if (hit_dr) begin
          prdata_reg <= {24'h00_0000, read_view};
        end else if (hit_ctrl) begin
          prdata_reg <= {31'h0000_0000, dp_enable_reg};
        end else begin
          prdata_reg <= 32'h0000_0000;
        end
      end
    end
  end

  // ----------------------------------------
  // Port registers
  // ----------------------------------------
  // The mode strap is caught on the first edge after release, never under reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_done_reg <= 1'b0;
      port_direction_bits <= `P9PF_DDR_RST_SC;
    end else if (!init_done_reg) begin
      init_done_reg <= 1'b1;
      port_direction_bits <= mode_exp ? `P9PF_DDR_RST_EXP : `P9PF_DDR_RST_SC;
    end else if (wr_take && hit_ddr) begin
      port_direction_bits <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_data_latch <= `P9PF_DR_RST;
    end else if (wr_take && hit_dr) begin
      port_data_latch <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dp_enable_reg <= 1'b0;
    end else if (wr_take && hit_ctrl) begin
      dp_enable_reg <= pwdata[`P9PF_CTRL_DP_EN_BIT];
    end
  end

  // ----------------------------------------
  // Pin function mux
  // ----------------------------------------
  assign mx.mode_exp = mode_exp;
  assign mx.slave = slave;
  assign mx.hw_standby = hw_standby;
  assign mx.rd_n = rd_strobe_n;
  assign mx.wr_n = wr_strobe_n;
  assign mx.addr_stb_n = address_strobe_n;
  assign mx.rdy_n = dp_ready_n;
  assign mx.clk_lvl = sys_clk_level;
  assign mx.ddr = port_direction_bits;
  assign mx.dr = port_data_latch;

  p9pf_pin_mux u_mux (
    .m (mx.mux)
  );

  // Strobes idle high under reset; the mux takes over one edge later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_reg <= 8'hFF;
      pin_oe_reg <= 8'h00;
      pin_pullup_reg <= 8'h00;
    end else if (hw_standby) begin
      pin_out_reg <= mx.out_nx;
      pin_oe_reg <= mx.oe_nx;
      pin_pullup_reg <= mx.pu_nx;
    end else if (sw_standby) begin
      // Hold everything, park strobes and clock high
      pin_out_reg <= pin_out_reg | mx.strobe_mask;
    end else begin
      pin_out_reg <= mx.out_nx;
      pin_oe_reg <= mx.oe_nx;
      pin_pullup_reg <= mx.pu_nx;
    end
  end

  // Pin levels feed their consumers regardless of the direction bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_n_reg <= 3'h7;
      adc_trigger_n_reg <= 1'b1;
      bus_wait_n_reg <= 1'b1;
      dp_select_n_reg <= 1'b1;
      dp_output_en_n_reg <= 1'b1;
      dp_write_en_n_reg <= 1'b1;
    end else begin
      irq_n_reg <= {pin_in[0], pin_in[1], pin_in[2]};
      adc_trigger_n_reg <= pin_in[0];
      bus_wait_n_reg <= mode_exp ? pin_in[`P9PF_PIN_WT] : 1'b1;
      dp_write_en_n_reg <= slave ? pin_in[`P9PF_PIN_WT] : 1'b1;
      dp_select_n_reg <= slave ? pin_in[`P9PF_PIN_RD] : 1'b1;
      dp_output_en_n_reg <= slave ? pin_in[`P9PF_PIN_WR] : 1'b1;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign pin_out = pin_out_reg;
  assign pin_oe = pin_oe_reg;
  assign pin_pullup = pin_pullup_reg;
  assign irq_n = irq_n_reg;
  assign adc_trigger_n = adc_trigger_n_reg;
  assign bus_wait_n = bus_wait_n_reg;
  assign dp_select_n = dp_select_n_reg;
  assign dp_output_en_n = dp_output_en_n_reg;
  assign dp_write_en_n = dp_write_en_n_reg;
  assign dual_port_enable = dp_enable_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  logic active;
  assign active = init_done_reg && !hw_standby && !sw_standby;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_read_data;
    setup && !pwrite && hit_dr ##1 psel && penable |->
      prdata[7:0] == ($past(port_direction_bits) & $past(port_data_latch) |
                      ~$past(port_direction_bits) & $past(pin_in)) && pready;
  endproperty
  a_read_data: assert property (p_read_data) else $error("Port read value wrong");

  property p_gpio;
    active && !mode_exp && !dp_enable_reg |=>
      pin_oe[4:3] == $past(port_direction_bits[4:3]) &&
      pin_out[4:3] == $past(port_data_latch[4:3]);
  endproperty
  a_gpio: assert property (p_gpio) else $error("General pin not following latch");

  property p_pullup;
    active && !mode_exp && !port_direction_bits[1] |=> pin_pullup[1] == $past(port_data_latch[1]);
  endproperty
  a_pullup: assert property (p_pullup) else $error("Pull-up not following data bit");

  property p_irq;
    init_done_reg |=> irq_n[2] == $past(pin_in[0]) && adc_trigger_n == $past(pin_in[0]) &&
        irq_n[0] == $past(pin_in[2]);
  endproperty
  a_irq: assert property (p_irq) else $error("Interrupt input not from pin");

  property p_strobes;
    active && mode_exp |=> pin_oe[6:3] == 4'hF && pin_pullup[6:3] == 4'h0 &&
      pin_out[3] == $past(rd_strobe_n) && pin_out[5] == $past(address_strobe_n) &&
      pin_oe[7] == 1'b0;
  endproperty
  a_strobes: assert property (p_strobes) else $error("Bus strobe pins wrong");

  property p_slave;
    active && slave |=> {pin_oe[7], pin_oe[5:3]} == 4'b0100 &&
      pin_pullup[3] == $past(~port_direction_bits[3] & port_data_latch[3]) &&
      pin_out[5] == $past(dp_ready_n) && dp_select_n == $past(pin_in[3]);
  endproperty
  a_slave: assert property (p_slave) else $error("Slave pins wrong");

  property p_clock;
    active && !mode_exp && port_direction_bits[6] |=>
      pin_oe[6] && pin_out[6] == $past(sys_clk_level);
  endproperty
  a_clock: assert property (p_clock) else $error("Clock output wrong");

  property p_reset_ddr;
    presetn && !init_done_reg |=> port_direction_bits ==
      (is_expanded($past(mode_sel)) ? `P9PF_DDR_RST_EXP : `P9PF_DDR_RST_SC);
  endproperty
  a_reset_ddr: assert property (p_reset_ddr) else $error("Direction reset wrong");

  property p_hw_standby;
    hw_standby |=> pin_oe == 8'h00 && pin_pullup == 8'h00;
  endproperty
  a_hw_standby: assert property (p_hw_standby) else $error("Standby pins driven");

  property p_sw_standby;
    init_done_reg && sw_standby && !hw_standby && mode_exp |=>
      pin_out[6:3] == 4'hF && $stable(pin_oe) && $stable(pin_pullup);
  endproperty
  a_sw_standby: assert property (p_sw_standby) else $error("Standby hold wrong");

  // Pins 0 to 2 keep their port function in every mode
  property p_low_pins;
    active |=> pin_oe[2:0] == $past(port_direction_bits[2:0]) &&
      pin_out[2:0] == $past(port_data_latch[2:0]);
  endproperty
  a_low_pins: assert property (p_low_pins) else $error("Low port pins wrong");

  property p_wait_in;
    active && mode_exp |=> bus_wait_n == $past(pin_in[`P9PF_PIN_WT]) &&
      !pin_oe[`P9PF_PIN_WT] &&
      pin_pullup[`P9PF_PIN_WT] == $past(~port_direction_bits[7] & port_data_latch[7]);
  endproperty
  a_wait_in: assert property (p_wait_in) else $error("Wait input pin wrong");

  // The state register mirrors pready; an error only shows in the access cycle
  property p_apb_phase;
    pready == (state_reg == p9pf_pkg::P9PF_ACCESS) && (!pslverr || pready);
  endproperty
  a_apb_phase: assert property (p_apb_phase) else $error("Bus phase wrong");

  c_write_dr: cover property (wr_take && hit_dr);
  c_expanded: cover property (active && mode_exp && wr_take && hit_ddr);
  c_slave: cover property (active && slave);
  c_sw_standby: cover property (sw_standby && mode_exp ##1 !sw_standby);
endmodule : p9pf_port

// ### common/p9pf_consts.svh
`ifndef P9PF_CONSTS_SVH
`define P9PF_CONSTS_SVH
// ----------------------------------------
// Register indices, byte address = index * 4
// ----------------------------------------
`define P9PF_DDR_IDX 16'hFFC0
`define P9PF_DR_IDX 16'hFFC1
`define P9PF_CTRL_IDX 16'hFFC2
// ----------------------------------------
// Reset values and fields
// ----------------------------------------
`define P9PF_DR_RST 8'h00
`define P9PF_DDR_RST_EXP 8'h40
`define P9PF_DDR_RST_SC 8'h00
`define P9PF_CTRL_DP_EN_BIT 0
`define P9PF_MODE_EXP1 2'h1
`define P9PF_MODE_EXP2 2'h2
`define P9PF_MODE_SC 2'h3
`define P9PF_PIN_RD 3
`define P9PF_PIN_WR 4
`define P9PF_PIN_ADDR 5
`define P9PF_PIN_CLK 6
`define P9PF_PIN_WT 7
`define P9PF_STROBE_MASK 8'h78
`endif

// ### common/p9pf_pkg.sv
package p9pf_pkg;
  typedef enum logic [0:0] {P9PF_IDLE, P9PF_ACCESS} p9pf_apb_state_t;
  typedef logic [7:0] p9pf_byte_t;
endpackage : p9pf_pkg

// ### common/p9pf_mux_if.sv
`timescale 1ns/100ps
interface p9pf_mux_if;
  logic mode_exp;
  logic slave;
  logic hw_standby;
  logic rd_n;
  logic wr_n;
  logic addr_stb_n;
  logic rdy_n;
  logic clk_lvl;
  p9pf_pkg::p9pf_byte_t ddr;
  p9pf_pkg::p9pf_byte_t dr;
  p9pf_pkg::p9pf_byte_t out_nx;
  p9pf_pkg::p9pf_byte_t oe_nx;
  p9pf_pkg::p9pf_byte_t pu_nx;
  p9pf_pkg::p9pf_byte_t strobe_mask;
  modport core (output mode_exp, slave, hw_standby, rd_n, wr_n, addr_stb_n, rdy_n, clk_lvl,
                output ddr, dr,
                input out_nx, oe_nx, pu_nx, strobe_mask);
  modport mux (input mode_exp, slave, hw_standby, rd_n, wr_n, addr_stb_n, rdy_n, clk_lvl,
               input ddr, dr,
               output out_nx, oe_nx, pu_nx, strobe_mask);
endinterface : p9pf_mux_if

// ### core/p9pf_pin_mux.sv
`timescale 1ns/100ps
`include "p9pf_consts.svh"
module p9pf_pin_mux (
  p9pf_mux_if.mux m
);
  // ----------------------------------------
  // Per-pin function selection
  // ----------------------------------------
  always_comb begin
    // General purpose by default
    m.oe_nx = m.ddr;
    m.out_nx = m.dr;
    m.pu_nx = ~m.ddr & m.dr;
    m.strobe_mask = 8'h00;
    if (m.mode_exp) begin
      m.oe_nx[`P9PF_PIN_RD] = 1'b1;
      m.oe_nx[`P9PF_PIN_WR] = 1'b1;
      m.out_nx[`P9PF_PIN_RD] = m.rd_n;
      m.out_nx[`P9PF_PIN_WR] = m.wr_n;
      m.pu_nx[`P9PF_PIN_RD] = 1'b0;
      m.pu_nx[`P9PF_PIN_WR] = 1'b0;
      m.oe_nx[`P9PF_PIN_ADDR] = 1'b1;
      m.out_nx[`P9PF_PIN_ADDR] = m.addr_stb_n;
      m.pu_nx[`P9PF_PIN_ADDR] = 1'b0;
      m.oe_nx[`P9PF_PIN_CLK] = 1'b1;
      m.out_nx[`P9PF_PIN_CLK] = m.clk_lvl;
      m.pu_nx[`P9PF_PIN_CLK] = 1'b0;
      m.oe_nx[`P9PF_PIN_WT] = 1'b0;
      m.strobe_mask = `P9PF_STROBE_MASK;
    end else begin
      // Single-chip: pin 6 is input or clock by its direction bit
      if (m.ddr[`P9PF_PIN_CLK]) begin
        m.out_nx[`P9PF_PIN_CLK] = m.clk_lvl;
        m.strobe_mask[`P9PF_PIN_CLK] = 1'b1;
      end
      if (m.slave) begin
        m.oe_nx[`P9PF_PIN_RD] = 1'b0;
        m.oe_nx[`P9PF_PIN_WR] = 1'b0;
        m.oe_nx[`P9PF_PIN_WT] = 1'b0;
        m.oe_nx[`P9PF_PIN_ADDR] = 1'b1;
        m.out_nx[`P9PF_PIN_ADDR] = m.rdy_n;
        m.pu_nx[`P9PF_PIN_ADDR] = 1'b0;
      end
    end
    if (m.hw_standby) begin
      m.oe_nx = 8'h00;
      m.pu_nx = 8'h00;
    end
  end
endmodule : p9pf_pin_mux

// ### tb/p9pf_pin_partner.sv
`timescale 1ns/100ps
module p9pf_pin_partner (
  // Clock
  input wire logic pclk,
  // Design side of the pins
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pullup,
  // Far-side drivers
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  // Resolved pin level
  output logic [7:0] pin_in
);
  logic [7:0] float_lvl = 8'h00;
  // A floating pin without pull-up flips every cycle, so it never looks stable;
  // the toggle starts at 8'h00 so an unknown start level cannot stick
  always @(posedge pclk) begin
    float_lvl <= ~float_lvl;
  end
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) |
                  (~pin_oe & ~ext_en & (pin_pullup | float_lvl));
endmodule : p9pf_pin_partner

// ### tb/tb_p9pf_port.sv
`timescale 1ns/100ps
`include "p9pf_consts.svh"
module tb_p9pf_port;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err;
  logic [1:0] mode_sel = 2'h3;
  logic hw_standby = 1'b0, sw_standby = 1'b0, sys_clk_level = 1'b1;
  logic rd_strobe_n = 1'b0, wr_strobe_n = 1'b1, address_strobe_n = 1'b0, dp_ready_n = 1'b0;
  logic [7:0] pin_in, pin_out, pin_oe, pin_pullup, ext_val = 8'h00, ext_en = 8'h00;
  logic [2:0] irq_n;
  logic adc_trigger_n, bus_wait_n, dp_select_n, dp_output_en_n, dp_write_en_n;
  logic dual_port_enable;
  int num_errors = 0, checked = 0;
  localparam logic [31:0] A_DDR = {14'h0, `P9PF_DDR_IDX, 2'h0};
  localparam logic [31:0] A_DR = {14'h0, `P9PF_DR_IDX, 2'h0};
  localparam logic [31:0] A_CTRL = {14'h0, `P9PF_CTRL_IDX, 2'h0};

  always #5 pclk = ~pclk;

  p9pf_port DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .mode_sel, .hw_standby, .sw_standby, .rd_strobe_n, .wr_strobe_n,
    .address_strobe_n, .dp_ready_n, .sys_clk_level, .pin_in, .pin_out, .pin_oe,
    .pin_pullup, .irq_n, .adc_trigger_n, .bus_wait_n, .dp_select_n, .dp_output_en_n,
    .dp_write_en_n, .dual_port_enable);
  p9pf_pin_partner far (.pclk, .pin_out, .pin_oe, .pin_pullup, .ext_val, .ext_en, .pin_in);

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a transfer that never completes
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rst(input logic [1:0] m);
    presetn <= 1'b0;
    mode_sel <= m;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask : rst

  // Pins follow one cycle after the latch, so three edges leave margin
  task settle;
    repeat (3) @(posedge pclk);
  endtask : settle

  task end_of_test;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test

  initial begin
    #100us;
    num_errors++;
    end_of_test;
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    rst(2'h3);
    ext_en <= 8'hFF;
    ext_val <= 8'hA5;
    settle;
    chk("oe", pin_oe, 8'h00);
    chk("pullup", pin_pullup, 8'h00);
    chk("irq", irq_n, 3'b101);
    chk("adc", adc_trigger_n, 1'b1);
    chk("wait", bus_wait_n, 1'b1);
    apb(1'b0, A_DR, 32'h0);
    chk("dr in", rd, 32'hA5);
    apb(1'b0, A_CTRL + 32'h4, 32'h0);
    chk("slverr", err, 1'b1);
    chk("unmapped", rd, 32'h0);
    $display("test reset single-chip done");
    // Far side releases before the port turns to outputs
    ext_en <= 8'h00;
    apb(1'b1, A_DDR, 32'hFF);
    apb(1'b0, A_DR, 32'h0);
    chk("dr rst", rd, 32'h00);
    apb(1'b1, A_DR, 32'h3C);
    settle;
    chk("out", pin_out, 8'h7C);
    chk("oe", pin_oe, 8'hFF);
    apb(1'b0, A_DR, 32'h0);
    chk("dr latch", rd, 32'h3C);
    ext_en <= 8'hF0;
    ext_val <= 8'h50;
    apb(1'b1, A_DDR, 32'h0F);
    settle;
    chk("pullup", pin_pullup, 8'h30);
    apb(1'b0, A_DR, 32'h0);
    chk("dr mix", rd, 32'h5C);
    ext_en <= 8'hB0;
    apb(1'b1, A_DR, 32'h0C);
    apb(1'b1, A_DDR, 32'h4F);
    settle;
    chk("pullup off", pin_pullup, 8'h00);
    chk("clk oe", pin_oe, 8'h4F);
    chk("clk hi", pin_out[6], 1'b1);
    sys_clk_level <= 1'b0;
    settle;
    chk("clk lo", pin_out[6], 1'b0);
    sys_clk_level <= 1'b1;
    $display("test general port done");
    ext_en <= 8'h98;
    ext_val <= 8'h10;
    apb(1'b1, A_DDR, 32'h0);
    apb(1'b1, A_DR, 32'h08);
    apb(1'b1, A_CTRL, 32'h1);
    settle;
    chk("dp enable", dual_port_enable, 1'b1);
    chk("slave in", {dp_select_n, dp_output_en_n, dp_write_en_n}, 3'b010);
    chk("rdy oe", pin_oe, 8'h20);
    chk("rdy out", pin_out[5], 1'b0);
    chk("pullup", pin_pullup, 8'h08);
    $display("test slave done");
    for (int m = 1; m <= 2; m++) begin
      rst(2'(m));
      ext_en <= 8'h80;
      ext_val <= 8'h00;
      settle;
      chk("strobe oe", pin_oe, 8'h78);
      chk("strobe out", pin_out[6:3], 4'hA);
      chk("pullup", pin_pullup, 8'h00);
      apb(1'b1, A_DDR, 32'h07);
      apb(1'b1, A_DR, 32'hFF);
      settle;
      chk("oe", pin_oe, 8'h7F);
      chk("out", pin_out[6:0], 7'h57);
      chk("pullup", pin_pullup, 8'h80);
      chk("wait", bus_wait_n, 1'b0);
      apb(1'b0, A_DR, 32'h0);
      chk("dr", rd, 32'h57);
      sw_standby <= 1'b1;
      settle;
      chk("sw out", pin_out[6:3], 4'hF);
      chk("sw oe", pin_oe, 8'h7F);
      hw_standby <= 1'b1;
      settle;
      chk("hw oe", pin_oe, 8'h00);
      chk("hw pullup", pin_pullup, 8'h00);
      hw_standby <= 1'b0;
      sw_standby <= 1'b0;
      $display("test expanded mode %0d done", m);
    end
    end_of_test;
  end
endmodule : tb_p9pf_port
